// ### core/multi_io_page_program.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// program fifo
// ------------------------------------------------------------------
module prog_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign out_data  = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else if (ce)
    begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (pop)
        rd_r <= rd_r + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wr_r[AW-1:0]] <= in_data;
  end
endmodule

// ------------------------------------------------------------------
// dual/quad page program command logic
// ------------------------------------------------------------------
module multi_io_page_program #(
  parameter int unsigned PAGE_CYCLES = flash_prog_pkg::PAGE_PROGRAM_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       cs_n,
  input  wire logic                       sck,
  input  wire flash_prog_pkg::lanes_s     lanes_in,
  output logic                            so_out,
  output logic                            so_oe,
  input  wire logic                       wel_set,
  input  wire logic                       wel_clear,
  input  wire logic                       quad_enable_bit,
  output logic [23:0]                     prot_addr,
  input  wire logic                       prot_hit,
  output logic                            arr_valid,
  input  wire logic                       arr_ready,
  output flash_prog_pkg::arr_word_s       arr_word,
  input  wire logic                       arr_fail,
  input  wire logic                       err_clear,
  output logic                            write_enable_latch,
  output logic                            ready_busy_flag,
  output logic                            erase_error_flag,
  output logic                            program_error_flag
);
  import flash_prog_pkg::*;

  // ----------------------------------------------------------------
  // link edges
  // ----------------------------------------------------------------
  logic sck_r;
  logic cs_n_r;
  // sample on the rising serial edge only, modes 0 and 3 alike
  wire  rise    = ~cs_n & sck & ~sck_r;
  wire  cs_rise = cs_n & ~cs_n_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sck_r  <= 1'b0;
      cs_n_r <= 1'b1;
    end
    else if (ce)
    begin
      sck_r  <= sck;
      cs_n_r <= cs_n;
    end
  end

  // ----------------------------------------------------------------
  // serial front end
  // ----------------------------------------------------------------
  ser_e        ser_r;
  logic [4:0]  cnt_r;
  logic [7:0]  cmd_r;
  logic [23:0] addr_r;
  logic        quad_r;
  logic        prot_r;
  logic [7:0]  shift_r;
  logic [2:0]  bitc_r;
  logic [7:0]  ptr_r;
  logic        got_r;
  logic        multi_r;
  logic [7:0]  page_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid_r;
  prog_e       ps_r;
  logic        wel_r;
  logic        busy_r;

  wire [7:0]  cmd_nxt  = {cmd_r[6:0], lanes_in.si};
  wire [23:0] addr_nxt = {addr_r[22:0], lanes_in.si};
  wire        is_prog  = (cmd_nxt == CMD_DUAL_PROG) || (cmd_nxt == CMD_QUAD_PROG);
  wire        is_quad  = cmd_nxt == CMD_QUAD_PROG;
  // busy array and missing latch both refuse the command outright
  wire        refuse   = busy_r | ~wel_r | (is_quad & ~quad_enable_bit);
  wire [2:0]  step     = quad_r ? QUAD_STEP : DUAL_STEP;
  // quad lanes carry hold,wp,so,si as bits high to low; dual so over si
  wire [7:0]  shift_nxt = quad_r ?
                          {shift_r[3:0], lanes_in.hold_n, lanes_in.wp_n,
                           lanes_in.so, lanes_in.si} :
                          {shift_r[5:0], lanes_in.so, lanes_in.si};
  wire [2:0]  bitc_nxt  = bitc_r + step;
  wire        byte_done = (ser_r == S_DATA) && rise && (bitc_nxt == 3'h0);
  wire        cmd_done  = (ser_r == S_CMD) && rise && (cnt_r == CMD_LAST_BIT);
  wire        new_cmd   = cmd_done && is_prog && !refuse;
  wire        addr_done = (ser_r == S_ADDR) && rise && (cnt_r == ADDR_LAST_BIT);

  // decisions taken when chip select is released
  wire in_prog   = (ser_r == S_ADDR) || (ser_r == S_DATA);
  wire complete  = (ser_r == S_DATA) && (bitc_r == 3'h0) && got_r;
  wire start     = cs_rise && complete && !prot_r;
  // partial address, missing or split byte: nothing is programmed
  wire abort     = cs_rise && in_prog && !start;
  wire abort_clr = abort && (quad_r || (complete && prot_r));

  assign prot_addr = addr_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ser_r <= S_CMD;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      if (cs_n)
      begin
        ser_r <= S_CMD;
        cnt_r <= '0;
      end
      else if (rise)
      begin
        cnt_r <= cnt_r + 5'h01;
        case (ser_r)
          S_CMD:
          begin
            if (cnt_r == CMD_LAST_BIT)
            begin
              cnt_r <= '0;
              if (cmd_nxt == CMD_ACTIVE_STATUS)
                ser_r <= S_STAT;
              else if (is_prog && !refuse)
                ser_r <= S_ADDR;
              else
                ser_r <= S_SKIP;
            end
          end
          S_ADDR:
          begin
            // so becomes an input only after the last address bit
            if (cnt_r == ADDR_LAST_BIT)
              ser_r <= S_DATA;
          end
          S_DATA:  ser_r <= S_DATA;
          S_STAT:  ser_r <= S_STAT;
          S_SKIP:  ser_r <= S_SKIP;
          default: ser_r <= S_SKIP;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_r   <= '0;
      addr_r  <= '0;
      quad_r  <= 1'b0;
      prot_r  <= 1'b0;
      shift_r <= '0;
      bitc_r  <= '0;
      ptr_r   <= '0;
      got_r   <= 1'b0;
      multi_r <= 1'b0;
    end
    else if (ce)
    begin
      if (ser_r == S_CMD && rise)
        cmd_r <= cmd_nxt;
      if (new_cmd)
      begin
        quad_r  <= is_quad;
        bitc_r  <= '0;
        got_r   <= 1'b0;
        multi_r <= 1'b0;
        prot_r  <= 1'b0;
      end
      if (ser_r == S_ADDR && rise)
        addr_r <= addr_nxt;
      if (addr_done)
        ptr_r <= addr_nxt[7:0];
      // protection lookup answers on the full address a cycle later
      if (ser_r == S_DATA && !got_r && bitc_r == 3'h0)
        prot_r <= prot_hit;
      if (ser_r == S_DATA && rise)
      begin
        shift_r <= shift_nxt;
        bitc_r  <= bitc_nxt;
      end
      if (byte_done)
      begin
        // pointer runs modulo the page: wrap and keep-last-256 in one
        ptr_r   <= ptr_r + 8'h01;
        got_r   <= 1'b1;
        multi_r <= got_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // page buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (ce && byte_done)
      page_r[ptr_r] <= shift_nxt;
  end

  genvar g;
  generate
    for (g = 0; g < PAGE_BYTES; g++)
    begin : g_valid
      always_ff @(posedge clk)
      begin
        if (rst)
          valid_r[g] <= 1'b0;
        else if (ce)
        begin
          // untouched locations stay erased: they are never pushed
          if (new_cmd)
            valid_r[g] <= 1'b0;
          else if (byte_done && ptr_r == 8'(g))
            valid_r[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // self-timed program sequencer
  // ----------------------------------------------------------------
  logic [7:0]         idx_r;
  logic [TIMER_W-1:0] tmr_r;
  logic               dual_r;
  logic               f_ready;
  logic               f_valid;
  arr_word_s          f_in;

  wire push_want = (ps_r == P_PUSH) && valid_r[idx_r];
  wire advance   = (ps_r == P_PUSH) && (!valid_r[idx_r] || f_ready);
  wire prog_end  = (ps_r == P_WAIT) && (tmr_r == '0) && !f_valid;

  assign f_in = '{addr: {addr_r[23:8], idx_r}, data: page_r[idx_r]};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ps_r   <= P_IDLE;
      idx_r  <= '0;
      tmr_r  <= '0;
      busy_r <= RST_BUSY;
      dual_r <= 1'b0;
    end
    else if (ce)
    begin
      if (tmr_r != '0)
        tmr_r <= tmr_r - 1'b1;
      case (ps_r)
        P_IDLE:
        begin
          if (start)
          begin
            ps_r   <= P_PUSH;
            idx_r  <= '0;
            busy_r <= 1'b1;
            dual_r <= !quad_r;
            tmr_r  <= multi_r ? TIMER_W'(PAGE_CYCLES) : TIMER_W'(BYTE_PROGRAM_CYCLES);
          end
        end
        P_PUSH:
        begin
          // a full fifo stalls the walk through the page
          if (advance)
          begin
            idx_r <= idx_r + 8'h01;
            if (idx_r == 8'hff)
              ps_r <= P_WAIT;
          end
        end
        P_WAIT:
        begin
          if (prog_end)
          begin
            ps_r   <= P_IDLE;
            busy_r <= 1'b0;
          end
        end
        default: ps_r <= P_IDLE;
      endcase
    end
  end

  prog_fifo #(
    .WIDTH ($bits(arr_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push_want),
    .in_ready  (f_ready),
    .in_data   (f_in),
    .out_valid (f_valid),
    .out_ready (arr_ready),
    .out_data  (arr_word)
  );

  assign arr_valid = f_valid;

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic ee_r;
  logic pe_r;
  wire  fail_evt = ce && arr_fail && f_valid && arr_ready;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wel_r <= RST_WEL;
      ee_r  <= RST_ERR;
      pe_r  <= RST_ERR;
    end
    else if (ce)
    begin
      if (wel_set)
        wel_r <= 1'b1;
      else if (wel_clear || abort_clr || prog_end)
        wel_r <= 1'b0;
      // a failure in the clearing cycle still sets its flag
      if (fail_evt)
      begin
        pe_r <= 1'b1;
        ee_r <= ee_r | dual_r;
      end
      else if (err_clear)
      begin
        pe_r <= 1'b0;
        ee_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // active status on so
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end
    else if (ce)
    begin
      so_out <= busy_r;
      so_oe  <= (ser_r == S_STAT) && !cs_n;
    end
  end

  assign write_enable_latch = wel_r;
  assign ready_busy_flag    = busy_r;
  assign erase_error_flag   = ee_r;
  assign program_error_flag = pe_r;
endmodule

// ### core/flash_prog_pkg.sv
package flash_prog_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DUAL_PROG     = 8'ha2;
  localparam logic [7:0] CMD_QUAD_PROG     = 8'h32;
  localparam logic [7:0] CMD_ACTIVE_STATUS = 8'h25;

  // ----------------------------------------------------------------
  // geometry and counts
  // ----------------------------------------------------------------
  localparam int          PAGE_BYTES   = 256;
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [4:0]  CMD_LAST_BIT = 5'h07;
  localparam logic [4:0]  ADDR_LAST_BIT = 5'h17;
  localparam logic [2:0]  DUAL_STEP    = 3'h2;
  localparam logic [2:0]  QUAD_STEP    = 3'h4;

  // ----------------------------------------------------------------
  // timing, clock 200 mhz
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS          = 5000;
  localparam int unsigned PAGE_PROGRAM_TIME_US   = 2000;
  localparam int unsigned BYTE_PROGRAM_TIME_NS   = 8000;
  // "about" these times, so nominal figures round down
  localparam int unsigned PAGE_PROGRAM_CYCLES =
    PAGE_PROGRAM_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int unsigned BYTE_PROGRAM_CYCLES =
    BYTE_PROGRAM_TIME_NS * 1000 / CLK_PERIOD_PS;
  localparam int          TIMER_W = 24;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_WEL  = 1'b0;
  localparam logic RST_BUSY = 1'b0;
  localparam logic RST_ERR  = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } arr_word_s;

  typedef struct packed {
    logic hold_n;
    logic wp_n;
    logic so;
    logic si;
  } lanes_s;

  typedef enum logic [4:0] {
    S_CMD  = 5'h01,
    S_ADDR = 5'h02,
    S_DATA = 5'h04,
    S_STAT = 5'h08,
    S_SKIP = 5'h10
  } ser_e;

  typedef enum logic [2:0] {
    P_IDLE = 3'h1,
    P_PUSH = 3'h2,
    P_WAIT = 3'h4
  } prog_e;

endpackage

// ### testbench/multi_io_page_program_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// protocol checks on the program block
// ----------------------------------------
module io_monitor
  import flash_prog_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      cs_n,
  input wire logic                      so_out,
  input wire logic                      so_oe,
  input wire logic                      wel_set,
  input wire logic [23:0]               prot_addr,
  input wire logic                      arr_valid,
  input wire logic                      arr_ready,
  input wire flash_prog_pkg::arr_word_s arr_word,
  input wire logic                      arr_fail,
  input wire logic                      err_clear,
  input wire logic                      write_enable_latch,
  input wire logic                      ready_busy_flag,
  input wire logic                      erase_error_flag,
  input wire logic                      program_error_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_cs_idle;
    cs_n [*3];
  endsequence
  sequence s_busy_start;
    !ready_busy_flag ##1 ready_busy_flag;
  endsequence

  property p_oe_release;
    s_cs_idle |-> !so_oe;
  endproperty
  property p_so_busy;
    so_oe && $past(so_oe) |-> so_out == $past(ready_busy_flag);
  endproperty
  property p_arr_busy;
    arr_valid |-> ready_busy_flag;
  endproperty
  property p_busy_cause;
    $rose(ready_busy_flag) |-> $past(cs_n);
  endproperty
  // self-timed: even the short page time is far above eight cycles
  property p_busy_min;
    s_busy_start |=> ready_busy_flag [*8];
  endproperty
  property p_arr_hold;
    arr_valid && !arr_ready |=> arr_valid && $stable(arr_word);
  endproperty
  property p_same_page;
    arr_valid |-> arr_word.addr[23:8] == prot_addr[23:8];
  endproperty
  property p_wel_set;
    wel_set |=> write_enable_latch;
  endproperty
  property p_fail_flag;
    arr_valid && arr_ready && arr_fail |=> program_error_flag;
  endproperty
  property p_err_clear;
    err_clear && !(arr_valid && arr_ready && arr_fail) |=>
      !program_error_flag && !erase_error_flag;
  endproperty
  property p_wel_done;
    $fell(ready_busy_flag) && !$past(wel_set) |-> !write_enable_latch;
  endproperty

  a_oe_release: assert property (p_oe_release) else $error("so driven after release");
  a_so_busy: assert property (p_so_busy) else $error("so does not follow busy");
  a_arr_busy: assert property (p_arr_busy) else $error("array write while idle");
  a_busy_cause: assert property (p_busy_cause) else $error("busy without release");
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  a_arr_hold: assert property (p_arr_hold) else $error("array word dropped");
  a_same_page: assert property (p_same_page) else $error("write left the page");
  a_wel_set: assert property (p_wel_set) else $error("latch not set");
  a_fail_flag: assert property (p_fail_flag) else $error("fail not flagged");
  a_err_clear: assert property (p_err_clear) else $error("flags not cleared");
  a_wel_done: assert property (p_wel_done) else $error("latch kept after program");
endmodule

bind multi_io_page_program io_monitor mon (.clk, .rst, .cs_n, .so_out, .so_oe, .wel_set,
  .prot_addr, .arr_valid, .arr_ready, .arr_word, .arr_fail, .err_clear, .write_enable_latch,
  .ready_busy_flag, .erase_error_flag, .program_error_flag);

// ### testbench/spi_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// host controller driving the serial link
// ----------------------------------------
module spi_host
  import flash_prog_pkg::*;
(
  input  wire logic              clk,
  output logic                   cs_n,
  output logic                   sck,
  output flash_prog_pkg::lanes_s lanes
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    lanes = 4'hf;
  end

  // the 257th and 258th bytes differ from the 1st and 2nd
  function automatic logic [7:0] pat(input int k);
    return (k[7:0] + 8'h3c) ^ {k[8], 7'h00};
  endfunction

  // lanes change while sck is low, the device samples on the rise
  task tick(input logic [3:0] v);
    @(posedge clk);
    sck <= 1'b0;
    lanes <= v;
    @(posedge clk);
    sck <= 1'b1;
  endtask

  task open(input logic [7:0] cmd);
    repeat (2) @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--)
      tick({2'b11, ~cmd[i], cmd[i]});
  endtask

  // released lines: hold and write-protect pulled up, so and si inverted
  task close;
    @(posedge clk);
    sck <= 1'b0;
    @(posedge clk);
    cs_n <= 1'b1;
    lanes <= {2'b11, ~lanes.so, ~lanes.si};
  endtask

  task send(input logic [7:0] cmd, input logic [23:0] a, input int alen,
            input int n, input logic quad, input int tail);
    logic [7:0] d;
    open(cmd);
    for (int i = 23; i > 23 - alen; i--)
      tick({2'b11, ~a[i], a[i]});
    for (int k = 0; k < n; k++)
    begin
      d = pat(k);
      if (quad)
      begin
        tick(d[7:4]);
        tick(d[3:0]);
      end
      else
        for (int j = 7; j > 0; j -= 2)
          tick({2'b11, d[j], d[j-1]});
    end
    for (int i = 0; i < tail; i++)
      tick(4'ha);
    close;
  endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import flash_prog_pkg::*;

  logic        clk, rst, ce, sck, cs_n, so_out, so_oe;
  logic        wel_set, wel_clear, err_clear, quad_enable_bit, prot_hit, prot_en;
  logic        arr_valid, arr_ready, arr_fail, stall;
  logic        write_enable_latch, ready_busy_flag, erase_error_flag, program_error_flag;
  logic [2:0]  ctl;
  logic [23:0] prot_addr;
  lanes_s      lanes_in;
  lanes_s      host_lanes;
  arr_word_s   arr_word;
  logic [7:0]  mem [256];
  int          wr_count;
  int          err_count;
  int          cmp_count;
  int          hi_n;

  assign {err_clear, wel_clear, wel_set} = ctl;
  assign prot_hit = prot_en && prot_addr[23:16] == 8'h0f;
  // the so wire carries the device while it drives it
  assign lanes_in = so_oe ? {host_lanes[3:2], so_out, host_lanes[0]} : host_lanes;

  multi_io_page_program #(.PAGE_CYCLES(50)) dut (.clk, .rst, .ce, .cs_n, .sck, .lanes_in,
    .so_out, .so_oe, .wel_set, .wel_clear, .quad_enable_bit, .prot_addr, .prot_hit,
    .arr_valid, .arr_ready, .arr_word, .arr_fail, .err_clear, .write_enable_latch,
    .ready_busy_flag, .erase_error_flag, .program_error_flag);
  spi_host host (.clk, .cs_n, .sck, .lanes(host_lanes));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // array side accepts every other cycle unless stalled
  always @(posedge clk)
  begin
    arr_ready <= stall ? 1'b0 : ~arr_ready;
    if (arr_valid && arr_ready)
    begin
      mem[arr_word.addr[7:0]] <= arr_word.data;
      wr_count <= wr_count + 1;
    end
  end

  // wide enough for a status pair in front of a 32-bit count
  task check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task strobe(input logic [2:0] v);
    @(posedge clk) ctl <= v;
    @(posedge clk) ctl <= 3'h0;
  endtask

  task settle;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4000 && ready_busy_flag !== 1'b0; i++)
      @(posedge clk);
    #1;
  endtask

  task clr;
    foreach (mem[i])
      mem[i] = 8'hff;
    wr_count = 0;
  endtask

  task t_dual_wrap;
    clr;
    strobe(3'h1);
    host.send(CMD_DUAL_PROG, 24'h0100fe, 24, 3, 1'b0, 0);
    check(wr_count, 0);
    settle;
    check(wr_count, 3);
    check({mem[8'hfe], mem[8'hff]}, {host.pat(0), host.pat(1)});
    check({mem[8'h00], mem[8'h01]}, {host.pat(2), 8'hff});
    check(write_enable_latch, 1'b0);
    $display("dual wrap done");
  endtask

  task t_quad_over;
    clr;
    strobe(3'h1);
    stall <= 1'b1;
    quad_enable_bit <= 1'b1;
    host.send(CMD_QUAD_PROG, 24'h020000, 24, 258, 1'b1, 0);
    repeat (200) @(posedge clk);
    #1;
    check({arr_valid, ready_busy_flag}, 2'h3);
    stall <= 1'b0;
    settle;
    check(wr_count, 256);
    for (int o = 0; o < 256; o++)
      check(mem[o], host.pat(o < 2 ? o + 256 : o));
    $display("quad overrun done");
  endtask

  task t_refused;
    clr;
    strobe(3'h2);
    host.send(CMD_DUAL_PROG, 24'h030000, 24, 1, 1'b0, 0);
    repeat (10) @(posedge clk);
    check({ready_busy_flag, write_enable_latch}, 2'h0);
    strobe(3'h1);
    quad_enable_bit <= 1'b0;
    host.send(CMD_QUAD_PROG, 24'h030000, 24, 1, 1'b1, 0);
    repeat (10) @(posedge clk);
    check({ready_busy_flag, write_enable_latch, wr_count}, {2'h1, 32'h0});
    $display("refused done");
  endtask

  task t_abort;
    host.send(CMD_DUAL_PROG, 24'h030000, 24, 1, 1'b0, 3);
    host.send(CMD_DUAL_PROG, 24'h030000, 24, 0, 1'b0, 0);
    repeat (10) @(posedge clk);
    check({ready_busy_flag, write_enable_latch, wr_count}, {2'h1, 32'h0});
    quad_enable_bit <= 1'b1;
    host.send(CMD_QUAD_PROG, 24'h030000, 12, 0, 1'b1, 0);
    repeat (10) @(posedge clk);
    check({ready_busy_flag, write_enable_latch}, 2'h0);
    strobe(3'h1);
    host.send(CMD_QUAD_PROG, 24'h030000, 24, 1, 1'b1, 1);
    repeat (10) @(posedge clk);
    check({ready_busy_flag, write_enable_latch, wr_count}, 34'h0);
    $display("abort done");
  endtask

  task t_protect;
    prot_en <= 1'b1;
    strobe(3'h1);
    host.send(CMD_DUAL_PROG, 24'h0f0010, 24, 1, 1'b0, 0);
    repeat (10) @(posedge clk);
    check({ready_busy_flag, write_enable_latch, wr_count}, 34'h0);
    prot_en <= 1'b0;
    $display("protect done");
  endtask

  task t_fail_status;
    arr_fail <= 1'b1;
    strobe(3'h1);
    host.send(CMD_DUAL_PROG, 24'h000040, 24, 1, 1'b0, 0);
    host.open(CMD_ACTIVE_STATUS);
    hi_n = 0;
    for (int i = 0; i < 2000; i++)
    begin
      host.tick(4'hf);
      #1;
      if (so_oe === 1'b1 && so_out === 1'b1)
        hi_n++;
      if (hi_n > 0 && so_out === 1'b0)
        break;
    end
    check(hi_n > 700, 1'b1);
    check({so_oe, ready_busy_flag}, 2'h2);
    host.close;
    check({erase_error_flag, program_error_flag}, 2'h3);
    strobe(3'h4);
    #1;
    check({erase_error_flag, program_error_flag}, 2'h0);
    strobe(3'h1);
    host.send(CMD_QUAD_PROG, 24'h000080, 24, 1, 1'b1, 0);
    settle;
    check({erase_error_flag, program_error_flag}, 2'h1);
    arr_fail <= 1'b0;
    $display("fail and status done");
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_of_test;
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    ctl = 3'h0;
    quad_enable_bit = 1'b0;
    prot_en = 1'b0;
    arr_ready = 1'b0;
    arr_fail = 1'b0;
    stall = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({so_oe, arr_valid, write_enable_latch, ready_busy_flag}, 4'h0);
    check({erase_error_flag, program_error_flag, prot_addr}, 26'h0);
    $display("reset done");
    t_dual_wrap;
    t_quad_over;
    t_refused;
    t_abort;
    t_protect;
    t_fail_status;
    end_of_test;
  end
endmodule
